/* design/rcfg_pkg.sv */
// Constants, types and register map for the radio address/CRC config block.
// Assumes a 250 MHz system clock and an AXI4-Lite master on the bus side.
package rcfg_pkg;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_MODE = 12'h510;
  localparam logic [11:0] OFF_PACKET_CONFIG_SECOND = 12'h518;
  localparam logic [11:0] OFF_BASE_ADDRESS_ZERO = 12'h51c;
  localparam logic [11:0] OFF_BASE_ADDRESS_ONE = 12'h520;
  localparam logic [11:0] OFF_PFX_LO = 12'h524;
  localparam logic [11:0] OFF_PFX_HI = 12'h528;
  localparam logic [11:0] OFF_TXSEL = 12'h52c;
  localparam logic [11:0] OFF_RXEN = 12'h530;
  localparam logic [11:0] OFF_CRC = 12'h534;
  localparam logic [11:0] OFF_POLY = 12'h538;
  localparam logic [11:0] OFF_SEED = 12'h53c;
  localparam logic [11:0] OFF_INTERFRAME_GAP_US = 12'h544;
  localparam logic [11:0] OFF_STATUS = 12'h5fc;
  // Field positions and widths
  localparam int CRC_LEN_LSB = 0;
  localparam int CRC_SKIP_LSB = 8;
  localparam int INTERFRAME_GAP_US_W = 10;
  localparam int CRC_W = 24;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Field encodings
  localparam logic [3:0] MODE_LR125 = 4'h5;
  localparam logic [3:0] MODE_LR500 = 4'h6;
  localparam logic [1:0] SKIP_INCLUDE = 2'h0;
  localparam logic [1:0] SKIP_ADDR = 2'h1;
  localparam logic [1:0] SKIP_15_4 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_RELOAD = 8'(CYC_PER_US - 1);

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} rcfg_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rcfg_rd_e;

  typedef struct packed {
    logic enable;
    logic [1:0] len;
    logic [2:0] start_sel;
    logic [CRC_W-1:0] poly;
    logic [CRC_W-1:0] seed;
  } rcfg_crc_s;

  typedef struct packed {
    logic [7:0] prefix;
    logic [31:0] base;
  } rcfg_txaddr_s;
endpackage : rcfg_pkg

/* design/rcfg_top.sv */
// Address, CRC and interframe-gap configuration of a radio packet engine.
// Assumes an AXI4-Lite master and a packet engine that pulses its events.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module rcfg_top
  import rcfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tx_start,
  input wire logic rx_addr_hit,
  input wire logic [2:0] rx_addr_index,
  input wire logic pkt_end,
  output rcfg_txaddr_s tx_addr,
  output logic tx_addr_valid,
  output rcfg_crc_s crc_cfg,
  output logic crc_load,
  output logic rx_accept,
  output logic rx_reject,
  output logic gap_busy,
  output logic gap_done,
  output logic long_range,
  output logic tx_500k
);

  typedef struct packed {
    rcfg_wr_e wr;
    rcfg_rd_e rd;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] mode;
    logic [31:0] packet_config_second;
    logic [31:0] base_address_zero;
    logic [31:0] base_address_one;
    logic [31:0] pfx_lo;
    logic [31:0] pfx_hi;
    logic [2:0] txsel;
    logic [7:0] rxen;
    logic [1:0] crclen;
    logic [1:0] crcskip;
    logic [CRC_W-1:0] poly;
    logic [CRC_W-1:0] seed;
    logic [INTERFRAME_GAP_US_W-1:0] interframe_gap_us;
    rcfg_txaddr_s tx_addr;
    logic tx_valid;
    rcfg_crc_s crc;
    logic crc_load;
    logic rx_accept;
    logic rx_reject;
    logic gap_busy;
    logic gap_done;
    logic [INTERFRAME_GAP_US_W-1:0] gap_us;
    logic [7:0] gap_sub;
    logic long_range;
    logic tx_500k;
  } rcfg_state_s;

  rcfg_state_s s;
  rcfg_state_s next_s;

  // Byte-enable merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (stb[i])
      begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Prefix byte of logical address idx, lane idx mod 4
  function automatic logic [7:0] prefix_of(input logic [31:0] lo,
                                           input logic [31:0] hi,
                                           input logic [2:0] idx);
    logic [31:0] w;
    w = idx[2] ? hi : lo;
    return w[8*idx[1:0] +: 8];
  endfunction : prefix_of

  // Word-aligned offset compare, low address bits ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction : hit

  // Next-state logic for bus, registers and packet-side outputs
  always_comb
  begin
    logic [31:0] m;
    logic [31:0] rd;
    logic ok;
    m = 32'h0000_0000;
    rd = 32'h0000_0000;
    ok = 1'b0;
    next_s = s;
    next_s.tx_valid = 1'b0;
    next_s.crc_load = 1'b0;
    next_s.rx_accept = 1'b0;
    next_s.rx_reject = 1'b0;
    next_s.gap_done = 1'b0;

    // Write channel: address and data taken in either order
    case (s.wr)
      WR_IDLE:
      begin
        if (awvalid && s.awready)
        begin
          next_s.aw_got = 1'b1;
          next_s.waddr = awaddr;
        end
        if (wvalid && s.wready)
        begin
          next_s.w_got = 1'b1;
          next_s.wdat = wdata;
          next_s.wstb = wstrb;
        end
        if (s.aw_got && s.w_got)
        begin
          m = merge(32'h0000_0000, s.wdat, s.wstb);
          ok = 1'b1;
          if (hit(s.waddr, OFF_MODE))
            next_s.mode = 4'(merge({28'h0, s.mode}, s.wdat, s.wstb));
          else if (hit(s.waddr, OFF_PACKET_CONFIG_SECOND))
            next_s.packet_config_second = merge(s.packet_config_second, s.wdat, s.wstb);
          else if (hit(s.waddr, OFF_BASE_ADDRESS_ZERO))
            next_s.base_address_zero = merge(s.base_address_zero, s.wdat, s.wstb);
          else if (hit(s.waddr, OFF_BASE_ADDRESS_ONE))
            next_s.base_address_one = merge(s.base_address_one, s.wdat, s.wstb);
          else if (hit(s.waddr, OFF_PFX_LO))
            next_s.pfx_lo = merge(s.pfx_lo, s.wdat, s.wstb);
          else if (hit(s.waddr, OFF_PFX_HI))
            next_s.pfx_hi = merge(s.pfx_hi, s.wdat, s.wstb);
          else if (hit(s.waddr, OFF_TXSEL))
            next_s.txsel = 3'(merge({29'h0, s.txsel}, s.wdat, s.wstb));
          else if (hit(s.waddr, OFF_RXEN))
            next_s.rxen = 8'(merge({24'h0, s.rxen}, s.wdat, s.wstb));
          else if (hit(s.waddr, OFF_CRC))
          begin
            m = merge({22'h0, s.crcskip, 6'h0, s.crclen}, s.wdat, s.wstb);
            next_s.crclen = m[CRC_LEN_LSB +: 2];
            next_s.crcskip = m[CRC_SKIP_LSB +: 2];
          end
          else if (hit(s.waddr, OFF_POLY))
            next_s.poly = CRC_W'(merge({8'h0, s.poly}, s.wdat, s.wstb));
          else if (hit(s.waddr, OFF_SEED))
            next_s.seed = CRC_W'(merge({8'h0, s.seed}, s.wdat, s.wstb));
          else if (hit(s.waddr, OFF_INTERFRAME_GAP_US))
            next_s.interframe_gap_us = INTERFRAME_GAP_US_W'(merge({22'h0, s.interframe_gap_us}, s.wdat, s.wstb));
          else if (!hit(s.waddr, OFF_STATUS))
            ok = 1'b0;  // Unmapped: no effect, error answer
          next_s.aw_got = 1'b0;
          next_s.w_got = 1'b0;
          next_s.bvalid = 1'b1;
          next_s.bresp = ok ? RESP_OKAY : RESP_SLVERR;
          next_s.wr = WR_RESP;
        end
      end
      WR_RESP:
      begin
        if (bready)
        begin
          next_s.bvalid = 1'b0;
          next_s.wr = WR_IDLE;
        end
      end
      default:
        next_s.wr = WR_IDLE;
    endcase
    next_s.awready = (next_s.wr == WR_IDLE) && !next_s.aw_got;
    next_s.wready = (next_s.wr == WR_IDLE) && !next_s.w_got;

    // Read channel: data answered on the same edge that takes the address
    case (s.rd)
      RD_IDLE:
      begin
        if (arvalid && s.arready)
        begin
          ok = 1'b1;
          if (hit(araddr, OFF_MODE)) rd = {28'h0, s.mode};
          else if (hit(araddr, OFF_PACKET_CONFIG_SECOND)) rd = s.packet_config_second;
          else if (hit(araddr, OFF_BASE_ADDRESS_ZERO)) rd = s.base_address_zero;
          else if (hit(araddr, OFF_BASE_ADDRESS_ONE)) rd = s.base_address_one;
          else if (hit(araddr, OFF_PFX_LO)) rd = s.pfx_lo;
          else if (hit(araddr, OFF_PFX_HI)) rd = s.pfx_hi;
          else if (hit(araddr, OFF_TXSEL)) rd = {29'h0, s.txsel};
          else if (hit(araddr, OFF_RXEN)) rd = {24'h0, s.rxen};
          else if (hit(araddr, OFF_CRC))
            rd = {22'h0, s.crcskip, 6'h0, s.crclen};
          else if (hit(araddr, OFF_POLY)) rd = {8'h0, s.poly};
          else if (hit(araddr, OFF_SEED)) rd = {8'h0, s.seed};
          else if (hit(araddr, OFF_INTERFRAME_GAP_US)) rd = {22'h0, s.interframe_gap_us};
          else if (hit(araddr, OFF_STATUS))
            rd = {28'h0, s.tx_500k, s.long_range, s.crc.enable,
                  s.gap_busy};
          else ok = 1'b0;
          next_s.rdata = rd;
          next_s.rresp = ok ? RESP_OKAY : RESP_SLVERR;
          next_s.rvalid = 1'b1;
          next_s.rd = RD_RESP;
        end
      end
      RD_RESP:
      begin
        if (rready)
        begin
          next_s.rvalid = 1'b0;
          next_s.rd = RD_IDLE;
        end
      end
      default:
        next_s.rd = RD_IDLE;
    endcase
    next_s.arready = next_s.rd == RD_IDLE;

    // CRC settings follow the registers continuously
    next_s.crc.len = s.crclen;
    next_s.crc.enable = s.crclen != 2'h0;
    next_s.crc.start_sel = {s.crcskip == SKIP_15_4,
                            s.crcskip == SKIP_ADDR,
                            s.crcskip == SKIP_INCLUDE};
    next_s.crc.poly = s.poly;
    next_s.crc.seed = s.seed;
    next_s.long_range = (s.mode == MODE_LR125) ||
                        (s.mode == MODE_LR500);
    next_s.tx_500k = s.mode == MODE_LR500;

    // Transmit: resolve the on-air address and reload the CRC seed
    if (tx_start)
    begin
      next_s.tx_addr.base = (s.txsel == 3'h0) ? s.base_address_zero : s.base_address_one;
      next_s.tx_addr.prefix = prefix_of(s.pfx_lo, s.pfx_hi, s.txsel);
      next_s.tx_valid = 1'b1;
      next_s.crc_load = 1'b1;
    end

    // Receive: filter matched addresses by their enable bit
    if (rx_addr_hit)
    begin
      next_s.rx_accept = s.rxen[rx_addr_index];
      next_s.rx_reject = !s.rxen[rx_addr_index];
      // Or-ed so a same-cycle transmit start keeps its seed load
      next_s.crc_load = next_s.crc_load || s.rxen[rx_addr_index];
    end

    // Gap timer; a new packet end restarts it rather than queueing
    if (pkt_end)
    begin
      next_s.gap_us = s.interframe_gap_us;
      next_s.gap_sub = US_RELOAD;
      next_s.gap_busy = s.interframe_gap_us != '0;
      next_s.gap_done = s.interframe_gap_us == '0;
    end
    else if (s.gap_busy)
    begin
      if (s.gap_sub != 8'h00)
        next_s.gap_sub = s.gap_sub - 8'h01;
      else if (s.gap_us == 10'h001)
      begin
        next_s.gap_busy = 1'b0;
        next_s.gap_done = 1'b1;
      end
      else
      begin
        next_s.gap_us = s.gap_us - 10'h001;
        next_s.gap_sub = US_RELOAD;
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.wr <= WR_IDLE;
      s.rd <= RD_IDLE;
    end
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign tx_addr = s.tx_addr;
  assign tx_addr_valid = s.tx_valid;
  assign crc_cfg = s.crc;
  assign crc_load = s.crc_load;
  assign rx_accept = s.rx_accept;
  assign rx_reject = s.rx_reject;
  assign gap_busy = s.gap_busy;
  assign gap_done = s.gap_done;
  assign long_range = s.long_range;
  assign tx_500k = s.tx_500k;

  // Checks beside the logic
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pfx_low;
    tx_start && s.txsel == 3'h2 |=> tx_addr.prefix == $past(s.pfx_lo[23:16]);
  endproperty
  a_pfx_low: assert property (p_pfx_low) else $error("low prefix lane");
  property p_pfx_high;
    tx_start && s.txsel == 3'h7 |=> tx_addr.prefix == $past(s.pfx_hi[31:24]);
  endproperty
  a_pfx_high: assert property (p_pfx_high) else $error("high prefix");
  property p_txsel;
    tx_start |=> tx_addr_valid && tx_addr.prefix ==
      prefix_of($past(s.pfx_lo), $past(s.pfx_hi), $past(s.txsel));
  endproperty
  a_txsel: assert property (p_txsel) else $error("tx select");
  property p_base;
    tx_start |=> tx_addr.base ==
      (($past(s.txsel) == 3'h0) ? $past(s.base_address_zero) : $past(s.base_address_one));
  endproperty
  a_base: assert property (p_base) else $error("base choice");
  property p_rx;
    rx_addr_hit |=> rx_accept == $past(s.rxen[rx_addr_index]) &&
      rx_reject == !rx_accept;
  endproperty
  a_rx: assert property (p_rx) else $error("rx enable");
  property p_crc_off;
    s.crclen == 2'h0 |=> !crc_cfg.enable;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc off");
  property p_skip;
    s.crcskip == SKIP_ADDR |=> crc_cfg.start_sel == 3'b010;
  endproperty
  a_skip: assert property (p_skip) else $error("address skip");
  property p_std;
    s.crcskip == SKIP_15_4 |=> crc_cfg.start_sel == 3'b100;
  endproperty
  a_std: assert property (p_std) else $error("15.4 coverage");
  property p_seed;
    tx_start |=> crc_load && crc_cfg.seed == $past(s.seed);
  endproperty
  a_seed: assert property (p_seed) else $error("seed load");
  property p_gap;
    pkt_end && s.interframe_gap_us == 10'h001 ##1 !pkt_end[*8] |-> ##243 gap_done;
  endproperty
  a_gap: assert property (p_gap) else $error("gap length");
  property p_lr;
    s.mode == MODE_LR125 |=> long_range && !tx_500k;
  endproperty
  a_lr: assert property (p_lr) else $error("long range mode");

  c_tx: cover property (tx_start ##1 tx_addr_valid);
  c_rx_rej: cover property (rx_addr_hit ##1 rx_reject);
  c_gap: cover property (gap_busy ##1 gap_done);
  c_wr: cover property (bvalid && bready);
endmodule : rcfg_top
`default_nettype wire

/* bench/rcfg_air_peer.sv */
// Behavioural far-side radio that pulses packet events into the block.
// Assumes the bench calls its tasks from one process locked to aclk.
`timescale 1ns/1ns
`default_nettype none
module rcfg_air_peer
(
  input wire logic aclk,
  output logic tx_start,
  output logic rx_addr_hit,
  output logic [2:0] rx_addr_index,
  output logic pkt_end
);
  // Idle low from time zero
  initial
  begin
    tx_start = 1'b0;
    rx_addr_hit = 1'b0;
    rx_addr_index = 3'h0;
    pkt_end = 1'b0;
  end

  // Start of a transmitted packet, one cycle wide
  task automatic pulse_tx();
    @(posedge aclk);
    tx_start <= 1'b1;
    @(posedge aclk);
    tx_start <= 1'b0;
  endtask : pulse_tx

  // Address match; index inverted afterwards so stale values never help
  task automatic pulse_hit(input logic [2:0] idx);
    @(posedge aclk);
    rx_addr_hit <= 1'b1;
    rx_addr_index <= idx;
    @(posedge aclk);
    rx_addr_hit <= 1'b0;
    rx_addr_index <= ~idx;
  endtask : pulse_hit

  // Last bit of a packet has left the air
  task automatic pulse_end();
    @(posedge aclk);
    pkt_end <= 1'b1;
    @(posedge aclk);
    pkt_end <= 1'b0;
  endtask : pulse_end
endmodule : rcfg_air_peer
`default_nettype wire

/* bench/rcfg_tb_top.sv */
// Self-checking bench for the radio address and CRC configuration block.
// Assumes the design asserts its own rules; this checks port behaviour.
`timescale 1ns/1ns
`default_nettype none
module rcfg_tb_top
  import rcfg_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr;
  logic [ADDR_W-1:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic tx_start, rx_addr_hit, pkt_end, tx_addr_valid, crc_load;
  logic rx_accept, rx_reject, gap_busy, gap_done, long_range, tx_500k;
  logic [2:0] rx_addr_index;
  rcfg_txaddr_s tx_addr;
  rcfg_crc_s crc_cfg;
  int miscompares;
  int total_checks;
  int n;
  logic [7:0] rx_pat = 8'h5a;
  logic [11:0] offs [10] = '{OFF_BASE_ADDRESS_ZERO, OFF_BASE_ADDRESS_ONE, OFF_PFX_LO, OFF_PFX_HI,
    OFF_RXEN, OFF_CRC, OFF_POLY, OFF_SEED, OFF_INTERFRAME_GAP_US, OFF_MODE};
  logic [31:0] masks [10] = '{32'hffffffff, 32'hffffffff, 32'hffffffff,
    32'hffffffff, 32'hff, 32'h303, 32'hffffff, 32'hffffff, 32'h3ff, 32'hf};

  rcfg_top u_rcfg_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tx_start(tx_start), .rx_addr_hit(rx_addr_hit),
    .rx_addr_index(rx_addr_index), .pkt_end(pkt_end), .tx_addr(tx_addr),
    .tx_addr_valid(tx_addr_valid), .crc_cfg(crc_cfg),
    .crc_load(crc_load), .rx_accept(rx_accept), .rx_reject(rx_reject),
    .gap_busy(gap_busy), .gap_done(gap_done), .long_range(long_range),
    .tx_500k(tx_500k));

  rcfg_air_peer u_rcfg_air_peer (.aclk(aclk), .tx_start(tx_start),
    .rx_addr_hit(rx_addr_hit), .rx_addr_index(rx_addr_index),
    .pkt_end(pkt_end));

  // 250 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Both write channels offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    resp = bresp;
    bready <= 1'b0;
    check(bvalid, 1'b1, "write answer");
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    check(rvalid, 1'b1, "read answer");
  endtask : axi_read

  // Registered outputs settle one edge later; look just after it
  task automatic settle();
    @(posedge aclk);
    #1;
  endtask : settle

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Watchdog sized well above the roughly one thousand cycles the tests need
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then all-ones to expose field widths
    for (int i = 0; i < 10; i++)
    begin
      axi_read(offs[i]);
      check(rd, 32'h0, "reset value");
      axi_write(offs[i], 32'hffffffff);
      axi_read(offs[i]);
      check(rd, masks[i], "readback");
    end
    axi_read(OFF_TXSEL);
    check(rd, 32'h0, "reset txsel");
    axi_read(12'h540);
    check({resp, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
    axi_write(12'h540, 32'h1234);
    check(resp, RESP_SLVERR, "unmapped write");
    $display("test registers done");
    // Transmit address for every logical index
    axi_write(OFF_BASE_ADDRESS_ZERO, 32'h0a0b0c0d);
    axi_write(OFF_BASE_ADDRESS_ONE, 32'h51525354);
    axi_write(OFF_PFX_LO, 32'ha3a2a1a0);
    axi_write(OFF_PFX_HI, 32'ha7a6a5a4);
    for (int i = 0; i < 8; i++)
    begin
      axi_write(OFF_TXSEL, 32'(i));
      u_rcfg_air_peer.pulse_tx();
      #1;
      check({tx_addr_valid, crc_load}, 2'b11, "tx pulses");
      check(tx_addr, {8'ha0 + 8'(i), (i == 0) ? 32'h0a0b0c0d
        : 32'h51525354}, "tx address");
    end
    $display("test tx address done");
    // Receive enables, one address at a time
    axi_write(OFF_RXEN, 32'h5a);
    for (int i = 0; i < 8; i++)
    begin
      u_rcfg_air_peer.pulse_hit(3'(i));
      #1;
      check({rx_accept, rx_reject, crc_load},
        {rx_pat[i], !rx_pat[i], rx_pat[i]}, "rx gate");
    end
    $display("test rx enables done");
    // CRC length, coverage and seed
    axi_write(OFF_SEED, 32'habcdef);
    axi_write(OFF_POLY, 32'h00065b);
    for (int k = 0; k < 4; k++)
    begin
      axi_write(OFF_CRC, {22'h0, 2'(k), 6'h0, 2'(k)});
      settle();
      check({crc_cfg.enable, crc_cfg.len}, {k != 0, 2'(k)},
        "crc len");
      check(crc_cfg.start_sel, (k < 3) ? 3'h1 << k : 3'h0,
        "crc start");
      check({crc_cfg.poly, crc_cfg.seed}, {24'h00065b, 24'habcdef},
        "crc seed");
    end
    $display("test crc done");
    // Long-range modes, CRC count kept at three meanwhile
    axi_write(OFF_CRC, 32'h3);
    for (int m = 4; m < 7; m++)
    begin
      axi_write(OFF_MODE, 32'(m));
      settle();
      check({long_range, tx_500k}, {m > 4, m == 6}, "mode");
    end
    $display("test modes done");
    // Interframe gap in microseconds, zero, one and two
    for (int g = 0; g < 3; g++)
    begin
      axi_write(OFF_INTERFRAME_GAP_US, 32'(g));
      u_rcfg_air_peer.pulse_end();
      // A zero gap pulses done right after the end edge; look there first
      #1;
      check(gap_busy, g != 0, "gap busy");
      n = 0;
      while (gap_done !== 1'b1 && n < 2000)
      begin
        settle();
        n++;
      end
      check(n, CYC_PER_US * g, "gap length");
    end
    $display("test gap done");
    stop_test();
  end
endmodule : rcfg_tb_top
`default_nettype wire
